// ==== rtl/pds_pkg.sv ====
// ==========================================================================
// shared constants of the piezo drive sequencer
package pds_pkg;

  // ========================================================================
  // register offsets, written over the serial link as the pointer byte
  localparam logic [7:0] OFS_DIR_COUNT  = 8'h00;
  localparam logic [7:0] OFS_GATE_CFG   = 8'h01;
  localparam logic [7:0] OFS_PERIOD     = 8'h02;
  localparam logic [7:0] OFS_GATE_A_SET = 8'h03;
  localparam logic [7:0] OFS_GATE_B_RST = 8'h04;

  // ========================================================================
  // field positions
  localparam int DIR_BIT       = 7;
  localparam int COUNT_MSB     = 6;
  localparam int INIT_SKIP_BIT = 0;
  localparam int SWING_LSB     = 1;
  localparam int CLKSEL_LSB    = 3;
  localparam int GATE_MODE_BIT = 7;

  // ========================================================================
  // reset and test-load values
  localparam logic [7:0] RST_GATE_CFG   = 8'h00;
  localparam logic [7:0] RST_PERIOD     = 8'h00;
  localparam logic [7:0] RST_GATE_A_SET = 8'h00;
  localparam logic [7:0] RST_GATE_B_RST = 8'h00;
  localparam logic       RST_DIR        = 1'b0;
  localparam logic [7:0] TEST_PERIOD    = 8'h73;
  localparam logic [7:0] TEST_GATE_A    = 8'h15;
  localparam logic [7:0] TEST_GATE_B    = 8'h18;
  localparam logic [4:0] SYNC_RST       = 5'h18;

  // ========================================================================
  // counts and the bus address
  localparam logic [9:0]  PENDING_MAX = 10'h200;
  localparam logic [15:0] WAIT_STEPS  = 16'h0004;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [6:0]  BUS_ADDR    = 7'h72;

  // ========================================================================
  // state types
  typedef enum logic [2:0] {S_IDLE, S_MOVE, S_WAIT, S_SWING, S_RUN} pds_seq_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_DATA, I_SKIP} pds_i2c_t;

endpackage : pds_pkg

// ==== rtl/pds_piezo_drive_sequencer.sv ====
`timescale 1ns/1ps
module pds_piezo_drive_sequencer #(
  parameter logic [6:0]  DEV_ADDR        = pds_pkg::BUS_ADDR,
  parameter int unsigned STEP_PERIOD     = 1,
  parameter int unsigned INIT_MOVE_COUNT = 1
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic reset_pin_n_in,
  input  wire logic test_in,
  input  wire logic enable_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      gate_a_out,
  output logic      gate_b_out,
  output logic      direction_out,
  output logic      busy_out
);
  import pds_pkg::*;

  // ========================================================================
  // pin synchronisers
  logic [4:0] raw_w;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       en_p_q;
  logic       scl_s, sda_s, en_s, test_s, rstn_s;

  assign raw_w = {scl_in, sda_in, enable_in, test_in, reset_pin_n_in};

  // two stages per pin; only the second stage is looked at by logic
  generate
    for (genvar g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          sync1_q[g] <= SYNC_RST[g];
          sync2_q[g] <= SYNC_RST[g];
        end else begin
          sync1_q[g] <= raw_w[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  assign {scl_s, sda_s, en_s, test_s, rstn_s} = sync2_q;

  // previous values for edge and start/stop detection
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      en_p_q  <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      en_p_q  <= en_s;
    end
  end

  // ========================================================================
  // serial write-only slave
  pds_i2c_t    i_state_q, i_state_d;
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [7:0]  shift_q, shift_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        ack_q, ack_d;
  logic        wr_q, wr_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [7:0]  wr_data_q, wr_data_d;
  logic        bus_start, bus_stop, scl_rise, scl_fall;

  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;

  // byte framing; ack is driven from the falling edge after bit 8 to the next
  always_comb begin
    i_state_d = i_state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    ptr_d     = ptr_q;
    ack_d     = ack_q;
    wr_d      = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (bus_start) begin
      i_state_d = I_ADDR;
      bit_cnt_d = 4'h0;
      ack_d     = 1'b0;
    end else if (bus_stop) begin
      i_state_d = I_IDLE;
      ack_d     = 1'b0;
    end else if (i_state_q != I_IDLE && i_state_q != I_SKIP) begin
      if (scl_rise && bit_cnt_q < BYTE_BITS) begin
        shift_d   = {shift_q[6:0], sda_s};
        bit_cnt_d = bit_cnt_q + 4'h1;
      end
      if (scl_fall && bit_cnt_q == BYTE_BITS) begin
        if (!ack_q) begin
          case (i_state_q)
            I_ADDR: begin
              // a read request is left unanswered, the master sees a nack
              if (shift_q[7:1] == DEV_ADDR && !shift_q[0]) ack_d = 1'b1;
              else i_state_d = I_SKIP;
            end
            I_PTR: begin
              ack_d = 1'b1;
              ptr_d = shift_q;
            end
            I_DATA: begin
              ack_d     = 1'b1;
              wr_d      = 1'b1;
              wr_addr_d = ptr_q;
              wr_data_d = shift_q;
            end
            default: i_state_d = I_SKIP;
          endcase
        end else begin
          ack_d     = 1'b0;
          bit_cnt_d = 4'h0;
          case (i_state_q)
            I_ADDR:  i_state_d = I_PTR;
            I_PTR:   i_state_d = I_DATA;
            I_DATA:  ptr_d = ptr_q + 8'h01; // consecutive bytes go to next register
            default: i_state_d = I_SKIP;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      i_state_q <= I_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      ack_q     <= 1'b0;
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      i_state_q <= i_state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      ack_q     <= ack_d;
      wr_q      <= wr_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // ========================================================================
  // configuration registers and pending count
  logic        dir_q, dir_d;
  logic [9:0]  pending_q, pending_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  period_q, period_d;
  logic [7:0]  gta_q, gta_d;
  logic [7:0]  gtb_q, gtb_d;
  logic        run_dec;
  logic [16:0] add_w;
  logic [16:0] sum_w;
  logic        wr_dir, dir_flip;

  assign wr_dir   = wr_q && wr_addr_q == OFS_DIR_COUNT;
  assign dir_flip = wr_dir && wr_data_q[DIR_BIT] != dir_q;
  assign add_w    = wr_dir ? 17'(wr_data_q[COUNT_MSB:0]) * 17'(STEP_PERIOD) : 17'h00000;

  // pending is one counter in periods; writes add, run periods take away
  always_comb begin
    dir_d    = dir_q;
    cfg_d    = cfg_q;
    period_d = period_q;
    gta_d    = gta_q;
    gtb_d    = gtb_q;
    sum_w    = dir_flip ? 17'h00000 : 17'(pending_q) - 17'(run_dec);
    sum_w    = sum_w + add_w;
    pending_d = (sum_w > 17'(PENDING_MAX)) ? PENDING_MAX : sum_w[9:0];
    if (wr_dir) dir_d = wr_data_q[DIR_BIT];
    if (wr_q && wr_addr_q == OFS_GATE_CFG) cfg_d = wr_data_q;
    // the test pin locks the waveform registers against serial writes
    if (wr_q && !test_s) begin
      if (wr_addr_q == OFS_PERIOD) period_d = wr_data_q;
      if (wr_addr_q == OFS_GATE_A_SET) gta_d = wr_data_q;
      if (wr_addr_q == OFS_GATE_B_RST) gtb_d = wr_data_q;
    end
    if (!rstn_s) begin
      dir_d     = RST_DIR;
      pending_d = 10'h000;
      cfg_d     = RST_GATE_CFG;
      period_d  = test_s ? TEST_PERIOD : RST_PERIOD;
      gta_d     = test_s ? TEST_GATE_A : RST_GATE_A_SET;
      gtb_d     = test_s ? TEST_GATE_B : RST_GATE_B_RST;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dir_q     <= RST_DIR;
      pending_q <= 10'h000;
      cfg_q     <= RST_GATE_CFG;
      period_q  <= RST_PERIOD;
      gta_q     <= RST_GATE_A_SET;
      gtb_q     <= RST_GATE_B_RST;
    end else begin
      dir_q     <= dir_d;
      pending_q <= pending_d;
      cfg_q     <= cfg_d;
      period_q  <= period_d;
      gta_q     <= gta_d;
      gtb_q     <= gtb_d;
    end
  end

  // ========================================================================
  // divider, period generator and run sequencer
  function automatic logic [15:0] swing_times(input logic [1:0] code);
    case (code)
      2'b00:   swing_times = 16'h0002;
      2'b01:   swing_times = 16'h0001;
      2'b10:   swing_times = 16'h0003;
      default: swing_times = 16'h0004;
    endcase
  endfunction : swing_times

  pds_seq_t    seq_q, seq_d;
  logic [1:0]  div_q, div_d;
  logic        tick_q, tick_d;
  logic [7:0]  phase_q, phase_d;
  logic [15:0] steps_q, steps_d;
  logic        init_dir_q, init_dir_d;
  logic        gate_a_q, gate_a_d;
  logic        gate_b_q, gate_b_d;
  logic        dir_out_q, dir_out_d;
  logic        busy_q, busy_d;
  logic        per_end, driving, en_rise, last_step;
  logic [1:0]  clksel;

  assign clksel    = cfg_q[CLKSEL_LSB+1:CLKSEL_LSB];
  assign en_rise   = en_s & ~en_p_q;
  assign per_end   = tick_q && phase_q == period_q && seq_q != S_IDLE;
  assign driving   = seq_q == S_MOVE || seq_q == S_SWING || seq_q == S_RUN;
  assign last_step = steps_q <= 16'h0001;
  assign run_dec   = seq_q == S_RUN && per_end && pending_q != 10'h000;

  always_comb begin
    div_d      = div_q + 2'h1;
    // divided clock is an enable pulse, one cycle in every 4, 2 or 1
    case (clksel)
      2'b00:   tick_d = div_q == 2'h3;
      2'b01:   tick_d = div_q[0];
      default: tick_d = 1'b1;
    endcase
    seq_d      = seq_q;
    phase_d    = phase_q;
    steps_d    = steps_q;
    init_dir_d = init_dir_q;
    if (tick_q && seq_q != S_IDLE) phase_d = per_end ? 8'h00 : phase_q + 8'h01;
    case (seq_q)
      S_IDLE: begin
        phase_d = 8'h00;
        if (en_rise && !cfg_q[INIT_SKIP_BIT]) begin
          seq_d      = S_MOVE;
          init_dir_d = dir_q;
          steps_d    = 16'(INIT_MOVE_COUNT) * 16'(STEP_PERIOD);
        end else if (en_s && pending_q != 10'h000) begin
          seq_d = S_RUN;
        end
      end
      S_MOVE: if (per_end) begin
        if (last_step) begin
          seq_d   = S_WAIT;
          steps_d = WAIT_STEPS * 16'(STEP_PERIOD);
        end else steps_d = steps_q - 16'h0001;
      end
      S_WAIT: if (per_end) begin
        if (last_step) begin
          seq_d   = S_SWING;
          steps_d = swing_times(cfg_q[SWING_LSB+1:SWING_LSB]) * 16'(STEP_PERIOD);
        end else steps_d = steps_q - 16'h0001;
      end
      S_SWING: if (per_end) begin
        if (last_step) seq_d = S_RUN;
        else steps_d = steps_q - 16'h0001;
      end
      S_RUN: if (pending_q == 10'h000 || (run_dec && pending_q == 10'h001)) seq_d = S_IDLE;
      default: seq_d = S_IDLE;
    endcase
    if (!en_s || !rstn_s) begin
      seq_d   = S_IDLE;
      phase_d = 8'h00;
      steps_d = 16'h0000;
    end
    // swing runs opposite to the initial move; idle gates follow gate mode
    case (seq_d)
      S_MOVE:  dir_out_d = init_dir_d;
      S_SWING: dir_out_d = ~init_dir_q;
      S_RUN:   dir_out_d = dir_q;
      default: dir_out_d = dir_out_q;
    endcase
    if (driving && seq_d != S_IDLE) begin
      gate_a_d = phase_d < gta_q;
      gate_b_d = phase_d >= gtb_q;
    end else begin
      gate_a_d = ~cfg_q[GATE_MODE_BIT];
      gate_b_d = ~cfg_q[GATE_MODE_BIT];
    end
    busy_d = seq_d != S_IDLE;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      seq_q      <= S_IDLE;
      div_q      <= 2'h0;
      tick_q     <= 1'b0;
      phase_q    <= 8'h00;
      steps_q    <= 16'h0000;
      init_dir_q <= 1'b0;
      gate_a_q   <= 1'b1;
      gate_b_q   <= 1'b1;
      dir_out_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      seq_q      <= seq_d;
      div_q      <= div_d;
      tick_q     <= tick_d;
      phase_q    <= phase_d;
      steps_q    <= steps_d;
      init_dir_q <= init_dir_d;
      gate_a_q   <= gate_a_d;
      gate_b_q   <= gate_b_d;
      dir_out_q  <= dir_out_d;
      busy_q     <= busy_d;
    end
  end

  // outputs straight from flip-flops except sda_out, tied to 0; the data line is only ever pulled low
  assign sda_out       = 1'b0;
  assign sda_oe_out    = ack_q;
  assign gate_a_out    = gate_a_q;
  assign gate_b_out    = gate_b_q;
  assign direction_out = dir_out_q;
  assign busy_out      = busy_q;

  // ========================================================================
  // assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_move_to_wait;
    seq_q == S_MOVE ##1 seq_q == S_WAIT;
  endsequence

  a_pending_cap: assert property (pending_q <= PENDING_MAX)
    else $error("pending count above cap");
  a_dir_clears: assert property (dir_flip && wr_data_q[COUNT_MSB:0] == 7'h00 && rstn_s |=> pending_q == 10'h000)
    else $error("direction change kept pending count");
  a_enable_stops: assert property (!en_s |=> seq_q == S_IDLE && !busy_q)
    else $error("drive continued with enable low");
  a_busy_tracks: assert property (seq_q != S_IDLE |-> busy_q)
    else $error("busy low while running");
  a_read_nack: assert property (i_state_q == I_ADDR && scl_fall && bit_cnt_q == BYTE_BITS && !ack_q && shift_q[0]
    && !bus_start && !bus_stop |=> !ack_q && i_state_q == I_SKIP)
    else $error("read request acknowledged");
  a_test_load: assert property (test_s && !rstn_s |=> period_q == TEST_PERIOD && gta_q == TEST_GATE_A
    && gtb_q == TEST_GATE_B)
    else $error("test values not loaded");
  a_run_decrement: assert property (run_dec && !wr_dir && rstn_s |=> pending_q == $past(pending_q) - 10'h001)
    else $error("pending not decremented");
  a_init_start: assert property (seq_q == S_IDLE && en_rise && !cfg_q[INIT_SKIP_BIT] && rstn_s |=> seq_q == S_MOVE)
    else $error("initialization not started");
  a_pin_reset: assert property (!rstn_s && !test_s |=> pending_q == 10'h000 && period_q == RST_PERIOD)
    else $error("reset pin did not clear registers");
  a_wait_length: assert property (s_move_to_wait |-> steps_q == WAIT_STEPS * 16'(STEP_PERIOD))
    else $error("wait length wrong");

endmodule : pds_piezo_drive_sequencer

// ==== tb/pds_i2c_host.sv ====
`timescale 1ns/1ps
// ==========================================================================
// serial host model: it drives every byte itself and never reads data back, even after a read request
module pds_i2c_host (
  input  wire logic clock_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  import pds_pkg::*;
  // eight clocks a phase, twice what the receiver's filter needs
  localparam int HALF = 8;

  // bus idle: clock high, data released to its pull-up
  initial begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_cyc

  // data moves only while the clock is low, a margin after the fall
  task automatic put_bit(input logic b);
    wait_cyc(2);
    sda_pull_out <= ~b;
    wait_cyc(HALF);
    scl_out <= 1'b1;
    wait_cyc(HALF);
    scl_out <= 1'b0;
  endtask : put_bit

  // start, bytes msb first each with an ack slot, then stop
  task automatic xfer(input logic [7:0] b [$], output logic [7:0] acks);
    acks = 8'h00;
    sda_pull_out <= 1'b1;
    wait_cyc(HALF);
    scl_out <= 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) put_bit(b[i][k]);
      wait_cyc(2);
      sda_pull_out <= 1'b0;   // hand the line to the receiver
      wait_cyc(HALF);
      scl_out <= 1'b1;
      wait_cyc(HALF / 2);
      acks[i] = (sda_in === 1'b0);
      wait_cyc(HALF / 2);
      scl_out <= 1'b0;
    end
    wait_cyc(2);
    sda_pull_out <= 1'b1;
    wait_cyc(HALF);
    scl_out <= 1'b1;
    wait_cyc(HALF);
    sda_pull_out <= 1'b0;     // stop, then bus free time
    wait_cyc(HALF);
  endtask : xfer
endmodule : pds_i2c_host

// ==== tb/pds_piezo_drive_sequencer_test.sv ====
`timescale 1ns/1ps
// ==========================================================================
// one compare: counts every check, reports and counts a mismatch
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); \
  end \
end

module pds_piezo_drive_sequencer_test;
  import pds_pkg::*;
  // about 25k cycles of frames and runs are expected
  localparam int LIMIT = 60000;

  logic       clock_in;
  logic       reset_in;
  logic       reset_pin_n;
  logic       test_pin;
  logic       enable;
  logic       scl, host_pull, sda, sda_oe, sda_drv;
  logic       gate_a, gate_b, gate_a_prev, gate_b_prev, direction, busy;
  logic       exp_dir     = 1'b0;
  logic [7:0] acks;
  int         cyc         = 0;
  int         bcnt        = 0;
  int         fcnt        = 0;
  int         gcnt        = 0;
  int         rcnt        = 0;
  int         num_errors  = 0;
  int         checks_done = 0;

  // open-drain line: pull-up wins unless someone pulls low
  assign sda = ~(host_pull | (sda_oe & ~sda_drv));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  pds_piezo_drive_sequencer DUT (
    .clock_in       (clock_in),
    .reset_in       (reset_in),
    .reset_pin_n_in (reset_pin_n),
    .test_in        (test_pin),
    .enable_in      (enable),
    .scl_in         (scl),
    .sda_in         (sda),
    .sda_out        (sda_drv),
    .sda_oe_out     (sda_oe),
    .gate_a_out     (gate_a),
    .gate_b_out     (gate_b),
    .direction_out  (direction),
    .busy_out       (busy)
  );

  pds_i2c_host host (
    .clock_in     (clock_in),
    .sda_in       (sda),
    .scl_out      (scl),
    .sda_pull_out (host_pull)
  );

  // ========================================================================
  // busy cycles, gate A falls, gate B rises and off-direction cycles while busy, plus the hang limit
  always @(posedge clock_in) begin
    cyc++;
    if (busy === 1'b1) bcnt++;
    if (busy === 1'b1 && gate_a_prev === 1'b1 && gate_a === 1'b0) fcnt++;
    if (busy === 1'b1 && gate_b_prev === 1'b0 && gate_b === 1'b1) gcnt++;
    if (busy === 1'b1 && direction !== exp_dir) rcnt++;
    gate_a_prev = gate_a;
    gate_b_prev = gate_b;
    if (cyc == LIMIT) begin
      num_errors++;
      stop_test();
    end
  end

  // ========================================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    host.xfer('{{BUS_ADDR, 1'b0}, ofs, v}, acks);
    `CHK("write ack", 8'h07, acks)
  endtask : wr

  // bounded wait for a busy level; a miss shows as a wrong level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clock_in);
      n++;
    end
    `CHK("busy level", lvl, busy)
  endtask : wait_busy

  // start and finish latency are loose, so allow a small margin
  task automatic chk_near(input string n, input int e, input int g);
    checks_done++;
    if (g < e - 2 || g > e + 6) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_near

  // enable rise, whole run, then back to standby; f < 0 skips the fall count
  task automatic run(input int e, input int f);
    bcnt = 0;
    fcnt = 0;
    gcnt = 0;
    rcnt = 0;
    enable <= 1'b1;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, e + 40);
    enable <= 1'b0;
    chk_near("busy cycles", e, bcnt);
    if (f >= 0) `CHK("drive periods", f, fcnt)
  endtask : run

  task automatic pin_reset(input logic t);
    test_pin    <= t;
    reset_pin_n <= 1'b0;
    host.wait_cyc(6);
    reset_pin_n <= 1'b1;
    host.wait_cyc(6);
  endtask : pin_reset

  // ========================================================================
  // main sequence
  initial begin
    reset_in    = 1'b1;
    reset_pin_n = 1'b1;
    test_pin    = 1'b0;
    enable      = 1'b0;
    host.wait_cyc(20);
    reset_in <= 1'b0;
    host.wait_cyc(6);
    // a read request and a foreign address both go unanswered
    host.xfer('{{BUS_ADDR, 1'b1}, 8'h00}, acks);
    `CHK("read ack", 8'h00, acks)
    host.xfer('{{~BUS_ADDR, 1'b0}, 8'h00}, acks);
    `CHK("foreign ack", 8'h00, acks)
    // period of four ticks, gate edges at two and three, pointer steps
    host.xfer('{{BUS_ADDR, 1'b0}, OFS_PERIOD, 8'h03, 8'h02, 8'h03}, acks);
    `CHK("burst ack", 8'h1F, acks)
    // every divider code, count written while enable is low
    for (int k = 0; k < 4; k++) begin
      wr(OFS_GATE_CFG, {3'b000, k[1:0], 3'b001});
      wr(OFS_DIR_COUNT, 8'h03);
      run(12 * ((k == 0) ? 4 : (k == 1) ? 2 : 1), 3);
      `CHK("gate b rises", 3, gcnt)
    end
    // a direction change drops the earlier count before adding
    wr(OFS_DIR_COUNT, 8'h85);
    wr(OFS_DIR_COUNT, 8'h02);
    run(8, 2);
    wr(OFS_DIR_COUNT, 8'h82);
    run(8, -1);
    `CHK("direction", 1'b1, direction)
    // five full counts on two-tick periods stop at the ceiling
    wr(OFS_PERIOD, 8'h01);
    wr(OFS_GATE_A_SET, 8'h01);
    repeat (5) wr(OFS_DIR_COUNT, 8'h7F);
    run(1024, 512);
    // long periods; host halts with a direction flip and a zero count
    wr(OFS_PERIOD, 8'hFF);
    wr(OFS_DIR_COUNT, 8'h7F);
    enable <= 1'b1;
    wait_busy(1'b1, 20);
    wr(OFS_DIR_COUNT, 8'h80);
    wait_busy(1'b0, 300);
    // enable still high, so a new count starts at once; then standby
    wr(OFS_DIR_COUNT, 8'h7F);
    wait_busy(1'b1, 20);
    enable <= 1'b0;
    host.wait_cyc(8);
    `CHK("busy in standby", 1'b0, busy)
    // init runs: one move, four waits, the swing count, one run period
    wr(OFS_PERIOD, 8'h03);
    wr(OFS_DIR_COUNT, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_GATE_CFG, {3'b000, 2'b10, s[1:0], 1'b0});
      wr(OFS_DIR_COUNT, {s[0], 7'h01});
      exp_dir = s[0];
      run((6 + ((s == 0) ? 2 : (s == 1) ? 1 : s + 1)) * 4, -1);
      `CHK("swing cycles", 4 * ((s == 0) ? 2 : (s == 1) ? 1 : s + 1), rcnt)
    end
    // test pin with pin reset loads fixed timing and locks it
    pin_reset(1'b1);
    wr(OFS_PERIOD, 8'h00);
    wr(OFS_GATE_CFG, 8'h11);
    wr(OFS_DIR_COUNT, 8'h01);
    run(116, 1);
    `CHK("gate b rises", 1, gcnt)
    // a plain pin reset brings the timing back to zero; standby gate mode idles both gates low
    pin_reset(1'b0);
    wr(OFS_GATE_CFG, 8'h91);
    wr(OFS_DIR_COUNT, 8'h03);
    run(3, -1);
    `CHK("standby gate a", 1'b0, gate_a)
    `CHK("standby gate b", 1'b0, gate_b)
    stop_test();
  end
endmodule : pds_piezo_drive_sequencer_test
